// File: logic/timer_block.v
// Prescaler, four reloading timers, PWM and period measurement behind Wishbone.
// Notes on behaviour
// R01 - Halt prescaler before reading or loading it.
// R02 - Change timer count source only while stopped.
// R03 - Read timer count only after stopping it.
// R04 - Write timer count only after stopping it.
// R05 - Avoid underflow cycle when writing reload registers.
// R06 - Do not stop PWM timer at underflow.
// R07 - High reload must be at least one.
// R08 - Prescaler, timers 1-3 count on first rise.
// R09 - Timer 4 counts on rise after fall.
// R10 - Measuring: timer 1 flag marks completion, not underflow.
// R11 - Edges before timer runs produce no count.
// R12 - Disabling measurement may set timer 1 flag.
// R13 - Software masks, then clears flag after stopping.
// R14 - Measurement needs sync select bit cleared.
// R15 - Start timer right after enabling; stop before read.
// R16 - Timer 1 source must be much faster.
// R17 - Measured pin must not be timer 1 source.
// R18 - Interrupt-zero pin source needs input enable bit.
// R19 - Shared counter pin keeps port input available.
// R20 - Underflow reloads from reload register and continues.
`timescale 1ns/10ps
`include "timer_block_defines.vh"
module timer_block #(
	parameter W = 8
) (
	input wire ref_clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire counter_pin_zero_i,
	output reg counter_pin_zero_o,
	output reg counter_pin_zero_oe,
	input wire external_irq_zero_pin_i,
	output reg pwm_o,
	output reg first_timer_irq_flag_o
);
	reg rst_s1_q, rst_s2_q;
	wire rst_n = rst_s2_q;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Pin synchronisers; only the second stage is looked at.
	reg cntr_s1_q, cntr_s2_q, external_irq_zero_pin_s1_q, external_irq_zero_pin_s2_q;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cntr_s1_q <= 1'b0;
			cntr_s2_q <= 1'b0;
			external_irq_zero_pin_s1_q <= 1'b0;
			external_irq_zero_pin_s2_q <= 1'b0;
		end else begin
			cntr_s1_q <= counter_pin_zero_i;
			cntr_s2_q <= cntr_s1_q;
			external_irq_zero_pin_s1_q <= external_irq_zero_pin_i;
			external_irq_zero_pin_s2_q <= external_irq_zero_pin_s1_q;
		end
	end

	reg [7:0] ctrl_q, src_sel_q, pm_ctl_q, ext_in_q, port_q;
	reg [W-1:0] presc_cnt_q, presc_rld_q, high_rld_q;
	reg [W-1:0] rld_q [0:3];
	reg presc_out_q, main_div_q, t1_flag_q, pm_gate_q, meas_q;
	wire [W-1:0] cnt [0:3];
	wire [3:0] uf, tout;
	wire [3:0] src;
	wire [3:0] wr_cnt;

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_rd_flag = bus_req & ~wb_we_i;
	wire [7:0] wd = wb_dat_i[7:0];
	// One-hot timer select for count writes, so each generated timer needs no address arithmetic.
	wire cnt_win = wb_adr_i >= `OFS_T1CNT && wb_adr_i <= `OFS_T4CNT && wb_adr_i[1:0] == 2'h0;
	wire [3:0] cnt_hot = 4'h1 << (wb_adr_i[3:2] - 2'h3);

	// Input enable gates the interrupt-zero pin before it can be measured.
	wire external_irq_zero_pin_in = external_irq_zero_pin_s2_q & ext_in_q[`EXT_EXTERNAL_IRQ_ZERO_PIN_EN]; // R18
	wire meas_sig = pm_ctl_q[`PM_SRC_EXTERNAL_IRQ_ZERO_PIN] ? external_irq_zero_pin_in : cntr_s2_q;
	wire meas_rise = meas_sig & ~meas_q;
	wire pm_en = pm_ctl_q[`PM_ENABLE];
	wire t1_run = ctrl_q[`CTRL_T1_RUN];

	// Prescaler counts every clock while running; its output toggles on underflow.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_cnt_q <= {W{1'b0}};
			presc_out_q <= 1'b0;
			main_div_q <= 1'b0;
		end else begin
			main_div_q <= ~main_div_q;
			if (ctrl_q[`CTRL_PRESC_RUN]) begin
				if (presc_cnt_q == {W{1'b0}}) begin
					presc_cnt_q <= presc_rld_q; // R20
					presc_out_q <= ~presc_out_q;
				end else begin
					presc_cnt_q <= presc_cnt_q - {{(W-1){1'b0}}, 1'b1}; // R08
				end
			end else if (bus_wr && wb_adr_i == `OFS_PRESC) begin
				presc_cnt_q <= wd; // R01
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_timer
			wire prev = (i == 0) ? presc_out_q : tout[(i + 3) % 4];
			reg sel_src;
			always @* begin
				case (src_sel_q[2*i+1:2*i])
					`SRC_PRESC: sel_src = presc_out_q;
					`SRC_PREV: sel_src = prev;
					`SRC_CNTR: sel_src = cntr_s2_q;
					default: sel_src = main_div_q;
				endcase
			end
			assign src[i] = sel_src;
			assign wr_cnt[i] = bus_wr & cnt_win & cnt_hot[i]; // R04
			timer_unit #(
				.W(W),
				.FALL_FIRST(i == 3)
			) u_timer (
				.clk(ref_clk),
				.rst_n(rst_n),
				// Timer 1 only counts inside the measured interval while measuring.
				.run(ctrl_q[`CTRL_T1_RUN + i] & ((i != 0) | ~pm_en | pm_gate_q)), // R11
				.src(src[i]),
				.wr_cnt(wr_cnt[i]),
				.wr_data(wd),
				.reload(rld_q[i]),
				.use_high((i == 3) & ctrl_q[`CTRL_PWM_EXT]),
				.high_reload(high_rld_q),
				.cnt_q(cnt[i]),
				.uf_q(uf[i]),
				.out_q(tout[i])
			);
		end
	endgenerate

	// Register writes; the same write decode drives timer count loads above.
	integer k;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `RST_BYTE;
			src_sel_q <= `RST_BYTE;
			pm_ctl_q <= `RST_BYTE;
			ext_in_q <= `RST_BYTE;
			port_q <= `RST_BYTE;
			presc_rld_q <= `RST_RELOAD;
			high_rld_q <= `RST_RELOAD;
			for (k = 0; k < 4; k = k + 1)
				rld_q[k] <= `RST_RELOAD;
		end else if (bus_wr) begin
			case (wb_adr_i)
				`OFS_CTRL: ctrl_q <= wd;
				`OFS_SRC: src_sel_q <= wd; // R02
				`OFS_PRESC: presc_rld_q <= wd;
				`OFS_T4HIGH: high_rld_q <= wd; // R07
				`OFS_PMCTL: pm_ctl_q <= wd;
				`OFS_EXTIN: ext_in_q <= wd; // R14
				`OFS_PORT: port_q <= wd;
				default: begin
					// Reload writes take effect at the next underflow only.
					if (wb_adr_i >= `OFS_T1RLD && wb_adr_i <= `OFS_T4RLD)
						rld_q[wb_adr_i[3:2] - 2'h3] <= wd; // R05
				end
			endcase
		end
	end

	// Measurement: first edge opens the gate, second edge closes it and flags completion.
	wire flag_clr = bus_wr && wb_adr_i == `OFS_STATUS && wd[`ST_T1_FLAG];
	wire pm_stop = bus_wr && wb_adr_i == `OFS_PMCTL && pm_en && !wd[`PM_ENABLE];
	wire pm_done = pm_en && t1_run && pm_gate_q && meas_rise;
	wire flag_set = (pm_en ? pm_done : uf[0]) | (pm_stop & pm_gate_q); // R10 R12
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meas_q <= 1'b0;
			pm_gate_q <= 1'b0;
			t1_flag_q <= 1'b0;
		end else begin
			meas_q <= meas_sig;
			if (!pm_en || pm_stop)
				pm_gate_q <= 1'b0;
			else if (t1_run && meas_rise)
				pm_gate_q <= ~pm_gate_q; // R11
			// A new event in the clearing cycle still sets the flag.
			if (flag_set)
				t1_flag_q <= 1'b1;
			else if (flag_clr)
				t1_flag_q <= 1'b0; // R13
		end
	end

	// Counter pin: output mode drives timer 1 output, port input stays readable.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_pin_zero_o <= 1'b0;
			counter_pin_zero_oe <= 1'b0;
			pwm_o <= 1'b0;
			first_timer_irq_flag_o <= 1'b0;
		end else begin
			counter_pin_zero_oe <= ctrl_q[`CTRL_CNTR_OUT] | ctrl_q[`CTRL_PORT_DIR]; // R19
			counter_pin_zero_o <= ctrl_q[`CTRL_CNTR_OUT] ? tout[0] : port_q[0]; // R19
			pwm_o <= tout[3];
			first_timer_irq_flag_o <= t1_flag_q;
		end
	end

	// Wishbone answer: one wait state, ack for a single cycle, unmapped reads zero.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_rd_flag) begin
				case (wb_adr_i)
					`OFS_CTRL: wb_dat_o[7:0] <= ctrl_q;
					`OFS_SRC: wb_dat_o[7:0] <= src_sel_q;
					`OFS_PRESC: wb_dat_o[W-1:0] <= presc_cnt_q; // R01
					`OFS_T4HIGH: wb_dat_o[W-1:0] <= high_rld_q;
					`OFS_PMCTL: wb_dat_o[7:0] <= pm_ctl_q;
					`OFS_EXTIN: wb_dat_o[7:0] <= ext_in_q;
					`OFS_PORT: wb_dat_o[7:0] <= {7'h00, cntr_s2_q}; // R19
					`OFS_STATUS: wb_dat_o[3:0] <= {pm_gate_q, external_irq_zero_pin_s2_q, cntr_s2_q, t1_flag_q};
					default: begin
						if (wb_adr_i >= `OFS_T1CNT && wb_adr_i <= `OFS_T4CNT)
							wb_dat_o[W-1:0] <= cnt[wb_adr_i[3:2] - 2'h3]; // R03
						else if (wb_adr_i >= `OFS_T1RLD && wb_adr_i <= `OFS_T4RLD)
							wb_dat_o[W-1:0] <= rld_q[wb_adr_i[3:2] - 2'h3];
					end
				endcase
			end
		end
	end
endmodule // timer_block

// File: shared/timer_block_defines.vh
// Register offsets, field positions and reset values for the timer block.
`ifndef TIMER_BLOCK_DEFINES_VH
`define TIMER_BLOCK_DEFINES_VH
`define OFS_CTRL 6'h00
`define OFS_SRC 6'h04
`define OFS_PRESC 6'h08
`define OFS_T1CNT 6'h0c
`define OFS_T4CNT 6'h18
`define OFS_T1RLD 6'h1c
`define OFS_T4RLD 6'h28
`define OFS_T4HIGH 6'h2c
`define OFS_PMCTL 6'h30
`define OFS_EXTIN 6'h34
`define OFS_STATUS 6'h38
`define OFS_PORT 6'h3c
`define CTRL_PRESC_RUN 0
`define CTRL_T1_RUN 1
`define CTRL_PWM_EXT 5
`define CTRL_CNTR_OUT 6
`define CTRL_PORT_DIR 7
`define PM_SRC_EXTERNAL_IRQ_ZERO_PIN 0
`define PM_ENABLE 2
`define EXT_SYNC_SEL 0
`define EXT_EXTERNAL_IRQ_ZERO_PIN_EN 3
`define ST_T1_FLAG 0
`define ST_CNTR_PIN 1
`define ST_EXTERNAL_IRQ_ZERO_PIN_PIN 2
`define ST_PM_BUSY 3
`define SRC_PRESC 2'h0
`define SRC_PREV 2'h1
`define SRC_CNTR 2'h2
`define SRC_MAIN 2'h3
`define RST_BYTE 8'h00
`define RST_RELOAD 8'hff
`endif

// File: logic/timer_unit.v
// One 8-bit down counter with reload, start alignment and toggling output.
`timescale 1ns/10ps
module timer_unit #(
	parameter W = 8,
	parameter FALL_FIRST = 0
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire src,
	input wire wr_cnt,
	input wire [W-1:0] wr_data,
	input wire [W-1:0] reload,
	input wire use_high,
	input wire [W-1:0] high_reload,
	output reg [W-1:0] cnt_q,
	output reg uf_q,
	output reg out_q
);
	reg src_q;
	reg armed_q;
	wire rise = src & ~src_q;
	wire fall = ~src & src_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= 1'b0;
			armed_q <= 1'b0;
			cnt_q <= {W{1'b0}};
			uf_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			src_q <= src;
			uf_q <= 1'b0;
			if (!run) begin
				armed_q <= 1'b0;
				if (wr_cnt)
					cnt_q <= wr_data;
			end else if (!armed_q) begin
				// A late-start timer waits for a falling edge, so its first interval differs.
				if (FALL_FIRST == 0 || fall)
					armed_q <= 1'b1; // R08 R09
			end
			// A plain timer counts on the first rise after start; only the late-start one must be armed first.
			if (run && (armed_q || FALL_FIRST == 0) && rise) begin // R08
				if (cnt_q == {W{1'b0}}) begin
					uf_q <= 1'b1;
					out_q <= ~out_q;
					// The next interval is the high one when the output is about to go high.
					cnt_q <= (use_high && !out_q) ? high_reload : reload; // R20
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // timer_unit

// File: tb/pulse_src.sv
// Event source that drives the shared counter pin.
`timescale 1ns/10ps
module pulse_src (
	input wire clk,
	input wire en,
	output reg pin
);
	reg [7:0] cnt_q = 8'h00;
	initial pin = 1'b0;
	// A 40-cycle period keeps the pin far slower than the timer's count source.
	always @(posedge clk) begin
		cnt_q <= (!en || cnt_q == 8'h13) ? 8'h00 : cnt_q + 8'h01;
		if (!en) begin
			pin <= 1'b0;
		end else if (cnt_q == 8'h13) begin
			pin <= ~pin;
		end
	end
endmodule // pulse_src

// File: tb/timer_block_chk.sv
// Bus and flag assertions on the timer block ports.
`timescale 1ns/10ps
`include "timer_block_defines.vh"
module timer_block_chk (
	input wire ref_clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire counter_pin_zero_oe,
	input wire pwm_o,
	input wire first_timer_irq_flag_o
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire wr_ack = wb_we_i && wb_ack_o;
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper bits set");
	a_flag_read_copy: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `OFS_STATUS |->
		wb_dat_o[`ST_T1_FLAG] == first_timer_irq_flag_o) else $error("flag differs");
	a_flag_clear_cause: assert property ($fell(first_timer_irq_flag_o) |-> wr_ack || $past(wr_ack))
		else $error("flag lost");
	a_pin_drive_cause: assert property ($changed(counter_pin_zero_oe) |-> wr_ack || $past(wr_ack))
		else $error("pin enable moved");
	a_reset_quiet: assert property ($rose(rstn) |-> (!wb_ack_o && !pwm_o && !counter_pin_zero_oe) [*2])
		else $error("busy after reset");
endmodule // timer_block_chk
bind timer_block timer_block_chk timer_block_chk_i (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.counter_pin_zero_oe(counter_pin_zero_oe), .pwm_o(pwm_o), .first_timer_irq_flag_o(first_timer_irq_flag_o));

// File: tb/timer_block_tb.sv
// Self-checking bench for the timer block.
`timescale 1ns/10ps
`include "timer_block_defines.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module timer_block_tb;
	logic ref_clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0, src_en = 1'b0, external_irq_zero_pin = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [7:0] wdat = 8'h00;
	logic [7:0] q;
	wire [31:0] rdat;
	wire ack, pin_o, pin_oe, src_pin, pwm, flag;
	wire pin = pin_oe ? pin_o : src_pin;
	int num_errors = 0, total_checks = 0, cyc_n = 0, t0, t1, t2;
	always #2.5 ref_clk = ~ref_clk;
	timer_block timer_block_i (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack),
		.counter_pin_zero_i(pin), .counter_pin_zero_o(pin_o), .counter_pin_zero_oe(pin_oe),
		.external_irq_zero_pin_i(external_irq_zero_pin), .pwm_o(pwm), .first_timer_irq_flag_o(flag));
	pulse_src pulse_src_i (.clk(ref_clk), .en(src_en), .pin(src_pin));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge ref_clk);
		while (ack !== 1'b1) @(posedge ref_clk);
		q = rdat[7:0];
		req <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Waiting for low first keeps a stale flag from a clear in flight out of the timing.
	task automatic wait_flag(output int t);
		while (flag !== 1'b0) @(posedge ref_clk);
		while (flag !== 1'b1) @(posedge ref_clk);
		t = cyc_n;
	endtask
	task automatic wait_pwm(input logic v, output int t);
		while (pwm !== v) @(posedge ref_clk);
		t = cyc_n;
	endtask
	task automatic test_regs();
		wb(1'b0, `OFS_T1RLD, 8'h00);
		`CHK("reload reset", `RST_RELOAD, q)
		wb(1'b1, `OFS_T1CNT, 8'h33);
		wb(1'b0, `OFS_T1CNT, 8'h00);
		`CHK("stopped count", 8'h33, q)
		$display("test_regs end");
	endtask
	task automatic test_reload();
		wb(1'b1, `OFS_SRC, {6'h00, `SRC_MAIN});
		wb(1'b1, `OFS_T1RLD, 8'h07);
		wb(1'b1, `OFS_T1CNT, 8'h07);
		wb(1'b1, `OFS_CTRL, 8'h02);
		t0 = cyc_n;
		wait_flag(t1);
		wb(1'b1, `OFS_STATUS, 8'h01);
		wait_flag(t2);
		`CHK("reload period", 16, t2 - t1)
		`CHK("first underflow", 1'b1, t1 - t0 <= 18)
		wb(1'b1, `OFS_CTRL, 8'h00);
		wb(1'b1, `OFS_STATUS, 8'h01);
		$display("test_reload end");
	endtask
	task automatic test_measure();
		wb(1'b1, `OFS_EXTIN, 8'h00);
		wb(1'b1, `OFS_T1CNT, 8'hff);
		wb(1'b1, `OFS_PMCTL, 8'h04);
		src_en <= 1'b1;
		repeat (100) @(posedge ref_clk);
		wb(1'b0, `OFS_T1CNT, 8'h00);
		`CHK("idle count", 8'hff, q)
		`CHK("idle flag", 1'b0, flag)
		wb(1'b1, `OFS_CTRL, 8'h02);
		wait_flag(t1);
		wb(1'b1, `OFS_CTRL, 8'h00);
		wb(1'b1, `OFS_PMCTL, 8'h00);
		wb(1'b0, `OFS_T1CNT, 8'h00);
		`CHK("measured count", 8'heb, q)
		src_en <= 1'b0;
		wb(1'b1, `OFS_STATUS, 8'h01);
		$display("test_measure end");
	endtask
	task automatic test_port();
		external_irq_zero_pin <= 1'b1;
		wb(1'b1, `OFS_EXTIN, 8'h08);
		wb(1'b1, `OFS_PORT, 8'h01);
		wb(1'b1, `OFS_CTRL, 8'h80);
		repeat (4) @(posedge ref_clk);
		wb(1'b0, `OFS_PORT, 8'h00);
		`CHK("driven pin", 1'b1, pin_oe && pin_o)
		`CHK("input while driving", 1'b1, q[0])
		wb(1'b1, `OFS_CTRL, 8'h00);
		repeat (4) @(posedge ref_clk);
		wb(1'b0, `OFS_PORT, 8'h00);
		`CHK("input released", 1'b0, q[0])
		wb(1'b0, `OFS_STATUS, 8'h00);
		`CHK("external_irq_zero_pin level", 1'b1, q[`ST_EXTERNAL_IRQ_ZERO_PIN_PIN])
		$display("test_port end");
	endtask
	task automatic test_pwm();
		wb(1'b1, `OFS_PRESC, 8'h01);
		wb(1'b1, `OFS_T4RLD, 8'h02);
		wb(1'b1, `OFS_T4HIGH, 8'h01);
		wb(1'b1, `OFS_T4CNT, 8'h02);
		wb(1'b1, `OFS_CTRL, 8'h31);
		t0 = cyc_n;
		wait_pwm(1'b1, t1);
		// The first prescaler rise is lost because timer 4 waits for a falling edge first.
		`CHK("first pwm interval", 15, t1 - t0)
		wait_pwm(1'b0, t2);
		`CHK("pwm high", 8, t2 - t1)
		wait_pwm(1'b1, t0);
		`CHK("pwm low", 12, t0 - t2)
		// Stopping right after a rising output edge keeps clear of the next underflow.
		wb(1'b1, `OFS_CTRL, 8'h00);
		wb(1'b0, `OFS_PRESC, 8'h00);
		`CHK("halted prescaler", 8'h01, q)
		$display("test_pwm end");
	endtask
	task automatic test_stop();
		external_irq_zero_pin <= 1'b0;
		wb(1'b1, `OFS_PMCTL, 8'h05);
		wb(1'b1, `OFS_CTRL, 8'h02);
		external_irq_zero_pin <= 1'b1;
		repeat (8) @(posedge ref_clk);
		wb(1'b0, `OFS_STATUS, 8'h00);
		`CHK("gate open", 1'b1, q[`ST_PM_BUSY])
		`CHK("no early flag", 1'b0, q[`ST_T1_FLAG])
		wb(1'b1, `OFS_CTRL, 8'h00);
		// There is no interrupt enable in this block, so the flag is cleared after the stop.
		wb(1'b1, `OFS_PMCTL, 8'h01);
		`CHK("stop sets flag", 1'b1, flag)
		wb(1'b1, `OFS_STATUS, 8'h01);
		`CHK("flag cleared", 1'b0, flag)
		$display("test_stop end");
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		test_regs();
		test_reload();
		test_measure();
		test_port();
		test_pwm();
		test_stop();
		finish_test();
	end
endmodule // timer_block_tb
